// [logic/sfcfe_top.sv]
// Behaviour
// - serial_out changes only on serial clock falling edges, one bit each.
// - with write guard low, mapped sectors refuse program and erase.
// - protect_map cannot change while write guard is low.
// - program/erase under write guard low is discarded; idle on deselect.
// - arm protection and permanent lock still execute under write guard low.
// - reset pin low aborts work and holds the state machine idle.
// - internal power-on reset; reset pin level is free during power-up.
// - main memory programming is always one whole page.
// - erase by chip, sector, block or page.
// - each serial clock rising edge of opcode, address or input data moves one bit in.
// - all fields travel most significant bit first.
// - 264-byte pages: buffer byte address is nine bits.
// - 264-byte pages: 12-bit row_index then nine-bit byte_in_row.
// - 256-byte pages: buffer byte address is eight bits.
// - 256-byte pages: 20-bit flat_location, page above byte.
// - reads from main memory or either buffer; clock modes 0 and 3.
// - serial_in sampled on serial clock rising edges.
// - deselected: serial_out released, serial_in ignored.
// - select rising ends the instruction; self-timed work runs on.
`default_nettype none
module sfcfe_top import sfcfe_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	input wire logic reset_pin_n,
	input wire logic binary_pages,
	output logic so,
	output logic so_oe,
	output logic core_start,
	output var sfcfe_kind_t core_kind,
	output logic [ROW_W-1:0] core_row,
	input wire logic core_busy,
	output logic core_abort,
	output logic [ROW_W+BYTE_W-1:0] array_addr,
	output logic array_rd_req,
	input wire logic [DATA_W-1:0] array_rd_data,
	output logic cmd_rejected
);
	logic [1:0] rst_pipe;
	logic rst_sync_n;
	logic [SYNC_W-1:0] pin_s1;
	logic [SYNC_W-1:0] pin_s2;
	logic sck_d;
	logic cs_d;
	logic sck_rise;
	logic sck_fall;
	logic cs_hi;
	logic cs_rise;
	logic si_s;
	logic wp_s;
	logic dev_rst;
	logic bin;

	sfcfe_state_t state;
	sfcfe_class_t cls;
	sfcfe_class_t dec_cls;
	logic [7:0] opcode;
	logic [7:0] sh;
	logic [7:0] next_byte;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [4:0] in_cnt;
	logic hdr_done;
	logic buf_sel;
	logic [BYTE_W-1:0] buf_ptr;
	logic [BYTE_W-1:0] page_last;
	logic [ROW_W-1:0] arr_row;
	logic [BYTE_W-1:0] arr_byte;
	logic map_got;
	logic [7:0] map_data;
	logic fetch;
	logic rd_p1;
	logic rd_p2;
	logic [DATA_W-1:0] data_byte;
	logic [2:0] out_idx;
	logic [N_SECT-1:0] prot_map;
	logic [N_SECT-1:0] lock_map;
	logic prot_armed;
	logic [SECT_W-1:0] sect;
	logic sect_prot;
	logic any_prot;
	logic rej_dec;
	logic rej_commit;
	logic start_ok;
	logic [ROW_W-1:0] addr_row;
	logic hdr_sel;
	logic [ROW_W-1:0] hdr_row;
	logic [BYTE_W-1:0] hdr_byte;
	logic hdr_wrap;

	sfcfe_mem_if mem_bus (.clk(clk));

	sfcfe_buf_mem u_mem (
		.bus(mem_bus.mem)
	);

	// power-on reset is internal; rst_n comes from that circuit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'h1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_s1 <= SYNC_RST;
			pin_s2 <= SYNC_RST;
			sck_d <= SYNC_RST[5];
			cs_d <= SYNC_RST[4];
		end else begin
			pin_s1 <= {sck, cs_n, si, wp_n, reset_pin_n, binary_pages};
			pin_s2 <= pin_s1;
			sck_d <= pin_s2[5];
			cs_d <= pin_s2[4];
		end
	end

	assign sck_rise = pin_s2[5] & ~sck_d;
	assign sck_fall = ~pin_s2[5] & sck_d;
	assign cs_hi = pin_s2[4];
	assign cs_rise = pin_s2[4] & ~cs_d;
	assign si_s = pin_s2[3];
	assign wp_s = pin_s2[2];
	assign dev_rst = ~pin_s2[1];
	assign bin = pin_s2[0];

	assign next_byte = {sh[6:0], si_s};
	assign next_addr = {addr[ADDR_W-2:0], si_s};
	assign page_last = bin ? LAST_BIN : LAST_STD;

	function automatic sfcfe_class_t classify(input logic [7:0] op);
		unique case (op)
			OP_RD_ARRAY, OP_RD_BUF1, OP_RD_BUF2: classify = C_READ;
			OP_WR_BUF1, OP_WR_BUF2, OP_MAP_WR: classify = C_WRBUF;
			OP_PROG1, OP_PROG2, OP_ER_PAGE, OP_ER_BLOCK,
			OP_ER_SECT, OP_ER_CHIP: classify = C_PE;
			OP_ARM, OP_DISARM: classify = C_NOADDR;
			OP_LOCK: classify = C_ADDR;
			default: classify = C_NONE;
		endcase
	endfunction : classify

	function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a,
			input logic b);
		row_of = b ? a[19:8] : a[20:9];
	endfunction : row_of

	function automatic logic [BYTE_W-1:0] byte_of(input logic [ADDR_W-1:0] a,
			input logic b);
		byte_of = b ? {1'h0, a[7:0]} : a[8:0];
	endfunction : byte_of

	assign hdr_sel = (opcode == OP_RD_BUF2) || (opcode == OP_WR_BUF2);
	assign hdr_row = row_of(next_addr, bin);
	assign hdr_byte = byte_of(next_addr, bin);
	assign hdr_wrap = hdr_byte == page_last;
	assign addr_row = row_of(addr, bin);
	assign dec_cls = classify(next_byte);
	// write guard taken at decode time, not at deselect
	assign rej_dec = (state == ST_OPC) && sck_rise && (in_cnt == BIT_LAST)
		&& (dec_cls == C_PE) && !wp_s;
	assign fetch = ((state == ST_ADDR) && sck_rise && (in_cnt == ADDR_LAST)
		&& (cls == C_READ))
		|| ((state == ST_DOUT) && sck_fall && (out_idx == 3'h0));

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
			cls <= C_NONE;
			opcode <= 8'h00;
			sh <= 8'h00;
			addr <= 24'h000000;
			in_cnt <= 5'h00;
			hdr_done <= 1'h0;
			map_got <= 1'h0;
			map_data <= 8'h00;
		end else if (dev_rst || cs_hi) begin
			state <= ST_IDLE;
			in_cnt <= 5'h00;
			hdr_done <= 1'h0;
			map_got <= 1'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					state <= ST_OPC;
					in_cnt <= 5'h00;
				end
				ST_OPC: if (sck_rise) begin
					sh <= next_byte;
					in_cnt <= in_cnt + 5'h01;
					if (in_cnt == BIT_LAST) begin
						opcode <= next_byte;
						cls <= dec_cls;
						in_cnt <= 5'h00;
						if (rej_dec || dec_cls == C_NONE) begin
							state <= ST_DISCARD;
						end else if (dec_cls == C_NOADDR) begin
							hdr_done <= 1'h1;
							state <= ST_DIN;
						end else begin
							state <= ST_ADDR;
						end
					end
				end
				ST_ADDR: if (sck_rise) begin
					addr <= next_addr;
					in_cnt <= in_cnt + 5'h01;
					if (in_cnt == ADDR_LAST) begin
						in_cnt <= 5'h00;
						hdr_done <= 1'h1;
						state <= (cls == C_READ) ? ST_DOUT : ST_DIN;
					end
				end
				ST_DIN: if (sck_rise) begin
					sh <= next_byte;
					in_cnt <= (in_cnt == BIT_LAST) ? 5'h00 : in_cnt + 5'h01;
					if (in_cnt == BIT_LAST && opcode == OP_MAP_WR && !map_got) begin
						map_got <= 1'h1;
						map_data <= next_byte;
					end
				end
				ST_DOUT: begin
				end
				ST_DISCARD: begin
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// buffer and array pointers, buffer writes and read fetch pipeline
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			buf_sel <= 1'h0;
			buf_ptr <= 9'h000;
			arr_row <= 12'h000;
			arr_byte <= 9'h000;
			mem_bus.we <= 1'h0;
			mem_bus.addr <= 10'h000;
			mem_bus.wdata <= 8'h00;
			rd_p1 <= 1'h0;
			rd_p2 <= 1'h0;
			array_addr <= 21'h000000;
			array_rd_req <= 1'h0;
		end else begin
			mem_bus.we <= 1'h0;
			rd_p1 <= fetch && !cs_hi && !dev_rst;
			rd_p2 <= rd_p1;
			array_rd_req <= fetch && opcode == OP_RD_ARRAY && !cs_hi;
			if (state == ST_ADDR && sck_rise && in_cnt == ADDR_LAST) begin
				buf_sel <= hdr_sel;
				buf_ptr <= hdr_byte;
				arr_row <= hdr_row;
				arr_byte <= hdr_byte;
				// first read fetch leaves straight from the header bits
				if (fetch) begin
					mem_bus.addr <= {hdr_sel, hdr_byte};
					array_addr <= {hdr_row, hdr_byte};
					buf_ptr <= hdr_wrap ? 9'h000 : hdr_byte + 9'h001;
					arr_byte <= hdr_wrap ? 9'h000 : hdr_byte + 9'h001;
					arr_row <= hdr_wrap ? hdr_row + 12'h001 : hdr_row;
				end
			end else if (fetch) begin
				mem_bus.addr <= {buf_sel, buf_ptr};
				array_addr <= {arr_row, arr_byte};
				buf_ptr <= (buf_ptr == page_last) ? 9'h000 : buf_ptr + 9'h001;
				// array reads run on across pages and wrap at the end
				arr_byte <= (arr_byte == page_last) ? 9'h000 : arr_byte + 9'h001;
				if (arr_byte == page_last) begin
					arr_row <= arr_row + 12'h001;
				end
			end else if (state == ST_DIN && sck_rise && in_cnt == BIT_LAST
					&& cls == C_WRBUF && opcode != OP_MAP_WR && !cs_hi) begin
				mem_bus.we <= 1'h1;
				mem_bus.addr <= {buf_sel, buf_ptr};
				mem_bus.wdata <= next_byte;
				buf_ptr <= (buf_ptr == page_last) ? 9'h000 : buf_ptr + 9'h001;
			end
		end
	end

	// first fetch lands three cycles after the last address rising edge is seen,
	// in the same cycle as the following falling edge at this clock ratio
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			data_byte <= 8'h00;
			out_idx <= OUT_FIRST;
			so <= 1'h0;
			so_oe <= 1'h0;
		end else begin
			so_oe <= (state == ST_DOUT) && !cs_hi && !dev_rst;
			if (rd_p2) begin
				data_byte <= (opcode == OP_RD_ARRAY) ? array_rd_data
					: mem_bus.rdata;
			end
			if (state != ST_DOUT || cs_hi) begin
				out_idx <= OUT_FIRST;
			end else if (sck_fall) begin
				so <= data_byte[out_idx];
				out_idx <= out_idx - 3'h1;
			end
		end
	end

	assign sect = addr_row[ROW_W-1 -: SECT_W];
	assign sect_prot = lock_map[sect]
		| (prot_map[sect] & (prot_armed | !wp_s));
	assign any_prot = |(lock_map
		| (prot_map & {N_SECT{prot_armed | !wp_s}}));
	assign start_ok = !core_busy
		&& ((opcode == OP_ER_CHIP) ? !any_prot : !sect_prot);
	assign rej_commit = cs_rise && hdr_done && !dev_rst
		&& (((cls == C_PE) && !start_ok)
		|| ((opcode == OP_MAP_WR)
		&& (!wp_s || !map_got || lock_map[sect])));

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prot_map <= 16'h0000;
			lock_map <= 16'h0000;
			prot_armed <= 1'h0;
		end else if (cs_rise && hdr_done && !dev_rst) begin
			if (opcode == OP_ARM) begin
				prot_armed <= 1'h1;
			end
			if (opcode == OP_DISARM) begin
				prot_armed <= 1'h0;
			end
			if (opcode == OP_LOCK) begin
				lock_map[sect] <= 1'h1;
			end
			if (opcode == OP_MAP_WR && !rej_commit) begin
				prot_map[sect] <= (map_data != 8'h00);
			end
		end
	end

	// self-timed work is the core's; deselect does not stop it
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			core_start <= 1'h0;
			core_kind <= K_PROG1;
			core_row <= 12'h000;
			core_abort <= 1'h0;
			cmd_rejected <= 1'h0;
		end else begin
			core_abort <= dev_rst;
			cmd_rejected <= rej_dec || rej_commit;
			core_start <= cs_rise && hdr_done && !dev_rst && (cls == C_PE)
				&& start_ok;
			if (cs_rise && hdr_done && cls == C_PE) begin
				core_row <= row_of(addr, bin);
				unique case (opcode)
					OP_PROG1: core_kind <= K_PROG1;
					OP_PROG2: core_kind <= K_PROG2;
					OP_ER_PAGE: core_kind <= K_ER_PAGE;
					OP_ER_BLOCK: core_kind <= K_ER_BLOCK;
					OP_ER_SECT: core_kind <= K_ER_SECT;
					default: core_kind <= K_ER_CHIP;
				endcase
			end
		end
	end
endmodule : sfcfe_top
`default_nettype wire

// [logic/sfcfe_pkg.sv]
`default_nettype none
package sfcfe_pkg;
	localparam int ROW_W = 12;
	localparam int BYTE_W = 9;
	localparam int ADDR_W = 24;
	localparam int SECT_W = 4;
	localparam int N_SECT = 16;
	localparam int MEM_AW = 10;
	localparam int DATA_W = 8;
	localparam int SYNC_W = 6;
	// pin vector order: sck, cs_n, si, wp_n, reset_pin_n, binary_pages
	localparam logic [SYNC_W-1:0] SYNC_RST = 6'h1E;
	localparam logic [4:0] BIT_LAST = 5'h07;
	localparam logic [4:0] ADDR_LAST = 5'h17;
	localparam logic [2:0] OUT_FIRST = 3'h7;
	localparam logic [BYTE_W-1:0] LAST_STD = 9'h107;
	localparam logic [BYTE_W-1:0] LAST_BIN = 9'h0FF;
	localparam logic [7:0] OP_RD_ARRAY = 8'h03;
	localparam logic [7:0] OP_RD_BUF1 = 8'hD1;
	localparam logic [7:0] OP_RD_BUF2 = 8'hD3;
	localparam logic [7:0] OP_WR_BUF1 = 8'h84;
	localparam logic [7:0] OP_WR_BUF2 = 8'h87;
	localparam logic [7:0] OP_PROG1 = 8'h88;
	localparam logic [7:0] OP_PROG2 = 8'h89;
	localparam logic [7:0] OP_ER_PAGE = 8'h81;
	localparam logic [7:0] OP_ER_BLOCK = 8'h50;
	localparam logic [7:0] OP_ER_SECT = 8'h7C;
	localparam logic [7:0] OP_ER_CHIP = 8'hC7;
	localparam logic [7:0] OP_ARM = 8'hA9;
	localparam logic [7:0] OP_DISARM = 8'h9A;
	localparam logic [7:0] OP_LOCK = 8'h30;
	localparam logic [7:0] OP_MAP_WR = 8'hFC;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_OPC = 6'h02,
		ST_ADDR = 6'h04,
		ST_DIN = 6'h08,
		ST_DOUT = 6'h10,
		ST_DISCARD = 6'h20
	} sfcfe_state_t;
	typedef enum logic [2:0] {
		C_NONE = 3'h0,
		C_READ = 3'h1,
		C_WRBUF = 3'h2,
		C_PE = 3'h3,
		C_NOADDR = 3'h4,
		C_ADDR = 3'h5
	} sfcfe_class_t;
	typedef enum logic [2:0] {
		K_PROG1 = 3'h0,
		K_PROG2 = 3'h1,
		K_ER_PAGE = 3'h2,
		K_ER_BLOCK = 3'h3,
		K_ER_SECT = 3'h4,
		K_ER_CHIP = 3'h5
	} sfcfe_kind_t;
endpackage : sfcfe_pkg
`default_nettype wire

// [logic/sfcfe_mem_if.sv]
`default_nettype none
interface sfcfe_mem_if import sfcfe_pkg::*; #(
	parameter int AW = MEM_AW,
	parameter int DW = DATA_W
) (
	input wire logic clk
);
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input clk, input we, input addr, input wdata, output rdata);
endinterface : sfcfe_mem_if
`default_nettype wire

// [logic/sfcfe_buf_mem.sv]
`default_nettype none
module sfcfe_buf_mem import sfcfe_pkg::*; #(
	parameter int AW = MEM_AW,
	parameter int DW = DATA_W
) (
	sfcfe_mem_if.mem bus
);
	// two page buffers, selected by the top address bit
	logic [DW-1:0] store [2**AW];

	always_ff @(posedge bus.clk) begin
		if (bus.we) begin
			store[bus.addr] <= bus.wdata;
		end
		bus.rdata <= store[bus.addr];
	end
endmodule : sfcfe_buf_mem
`default_nettype wire

// [tb/sfcfe_top_asserts.sv]
`default_nettype none
module sfcfe_top_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic reset_pin_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic core_start,
	input wire logic core_abort,
	input wire logic array_rd_req
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] sck_h;
	logic [8:0] wp_lo;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_h <= 6'h00;
		end else begin
			sck_h <= {sck_h[4:0], sck};
		end
	end
	// run length of a low guard; decode sits under 300 cycles before commit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_lo <= 9'h000;
		end else if (wp_n) begin
			wp_lo <= 9'h000;
		end else if (wp_lo != 9'h1FF) begin
			wp_lo <= wp_lo + 9'h001;
		end
	end
	so_edge_a: assert property (
		$changed(so) && so_oe && $past(so_oe) |-> |(sck_h[5:1] & ~sck_h[4:0]))
		else $error("serial out moved without a clock fall");
	oe_release_a: assert property (cs_n [*6] |-> !so_oe)
		else $error("serial out driven while deselected");
	guard_drop_a: assert property (core_start |-> wp_lo < 9'h12C)
		else $error("start under a low write guard");
	abort_on_a: assert property (!reset_pin_n [*6] |-> core_abort)
		else $error("abort missing while reset pin low");
	abort_off_a: assert property (reset_pin_n [*6] |-> !core_abort)
		else $error("abort held after reset pin release");
	reset_idle_a: assert property (
		!reset_pin_n [*6] |-> !so_oe && !core_start && !array_rd_req)
		else $error("activity while reset pin low");
	start_commit_a: assert property (
		core_start |-> $past(cs_n) && $past(cs_n, 2) ##1 !core_start)
		else $error("start not at deselect or not one cycle");
	rd_pulse_a: assert property (array_rd_req |=> !array_rd_req)
		else $error("array read request longer than a cycle");
endmodule : sfcfe_top_asserts
bind sfcfe_top sfcfe_top_asserts u_sfcfe_top_asserts (
	.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .wp_n(wp_n),
	.reset_pin_n(reset_pin_n), .so(so), .so_oe(so_oe),
	.core_start(core_start), .core_abort(core_abort),
	.array_rd_req(array_rd_req)
);
`default_nettype wire

// [tb/sfcfe_host.sv]
`default_nettype none
module sfcfe_host (
	input wire logic clk,
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	input wire logic so,
	input wire logic so_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic idle_hi = 1'b0;
	logic so_last = 1'b0;
	initial sck = 1'b0;
	initial cs_n = 1'b1;
	initial si = 1'b0;
	// a released output shows the inverse, never a trusted stale bit
	always @(posedge clk) if (so_oe) so_last <= so;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick
	// mode 3 parks the clock high; its leading fall carries nothing
	task automatic open_frame(input logic mode3);
		idle_hi = mode3;
		sck = mode3;
		tick(4);
		cs_n = 1'b0;
		tick(4);
	endtask : open_frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			tick(5);
			sck = 1'b1;
			rx[i] = so_oe ? so : ~so_last;
			tick(3);
		end
	endtask : xfer
	task automatic close_frame;
		sck = idle_hi;
		tick(1);
		cs_n = 1'b1;
		si = ~si;
		tick(8);
	endtask : close_frame
endmodule : sfcfe_host
`default_nettype wire

// [tb/sfcfe_top_bench.sv]
`default_nettype none
module sfcfe_top_bench import sfcfe_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] ROW_A = {3'h0, 12'h2A5, 9'h000};
	localparam logic [23:0] ROW_P = {3'h0, 12'h140, 9'h000};
	logic clk = 1'b0;
	logic rst_n, sck, cs_n, si, wp_n, reset_pin_n, binary_pages, core_busy;
	logic so, so_oe, core_start, core_abort, array_rd_req, cmd_rejected;
	sfcfe_kind_t core_kind;
	logic [ROW_W-1:0] core_row, got_row;
	logic [ROW_W+BYTE_W-1:0] array_addr, first_addr;
	logic [DATA_W-1:0] array_rd_data;
	logic [2:0] got_kind;
	logic seen_start, seen_rej, seen_rd;
	logic [7:0] rx [4];
	int fails = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	sfcfe_top u_sfcfe_top (
		.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
		.wp_n(wp_n), .reset_pin_n(reset_pin_n), .binary_pages(binary_pages),
		.so(so), .so_oe(so_oe), .core_start(core_start),
		.core_kind(core_kind), .core_row(core_row), .core_busy(core_busy),
		.core_abort(core_abort), .array_addr(array_addr),
		.array_rd_req(array_rd_req), .array_rd_data(array_rd_data),
		.cmd_rejected(cmd_rejected)
	);
	sfcfe_host u_sfcfe_host (
		.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
	);
	function automatic logic [7:0] mem_f(input logic [20:0] a);
		return a[7:0] ^ a[16:9] ^ 8'h5A;
	endfunction : mem_f
	// array answers the cycle after the request; first address kept
	always @(posedge clk) begin
		if (array_rd_req) array_rd_data <= mem_f(array_addr);
		if (array_rd_req && !seen_rd) first_addr <= array_addr;
		if (array_rd_req) seen_rd <= 1'b1;
		if (cmd_rejected) seen_rej <= 1'b1;
		if (core_start) seen_start <= 1'b1;
		if (core_start) got_kind <= core_kind;
		if (core_start) got_row <= core_row;
	end
	task automatic chk(input logic [23:0] g, input logic [23:0] x);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input logic na, input int n, input logic [7:0] wd, input logic m3);
		logic [7:0] t;
		seen_start = 1'b0;
		seen_rej = 1'b0;
		seen_rd = 1'b0;
		u_sfcfe_host.open_frame(m3);
		u_sfcfe_host.xfer(op, t);
		for (int k = 2; k >= 0 && na; k--) begin
			u_sfcfe_host.xfer(a[k*8+:8], t);
		end
		for (int k = 0; k < n; k++) begin
			u_sfcfe_host.xfer(wd + 8'(k), rx[k]);
		end
		u_sfcfe_host.close_frame;
	endtask : frame
	task automatic outcome(input logic s, input logic r);
		u_sfcfe_host.tick(6);
		chk(24'(seen_start), 24'(s));
		chk(24'(seen_rej), 24'(r));
	endtask : outcome
	task automatic s_read(input logic bin, input logic [23:0] a);
		logic [20:0] e;
		e = bin ? {a[19:8], 1'b0, a[7:0]} : a[20:0];
		binary_pages = bin;
		frame(OP_RD_ARRAY, a, 1'b1, 2, 8'h00, bin);
		chk(24'(first_addr), 24'(e));
		chk(24'(rx[0]), 24'(mem_f(e)));
		chk(24'(rx[1]), 24'(mem_f(e + 21'h1)));
	endtask : s_read
	task automatic s_buf(input logic bin, input logic [7:0] wop,
		input logic [7:0] rop, input logic [23:0] a);
		binary_pages = bin;
		frame(wop, a, 1'b1, 2, 8'hC3, 1'b0);
		frame(rop, a, 1'b1, 2, 8'h00, 1'b1);
		chk(24'(rx[0]), 24'hC3);
		chk(24'(rx[1]), 24'hC4);
	endtask : s_buf
	task automatic s_core;
		logic [7:0] ops [6] = '{OP_PROG1, OP_PROG2, OP_ER_PAGE,
			OP_ER_BLOCK, OP_ER_SECT, OP_ER_CHIP};
		binary_pages = 1'b0;
		for (int k = 0; k < 6; k++) begin
			frame(ops[k], ROW_A, 1'b1, 0, 8'h00, 1'b0);
			outcome(1'b1, 1'b0);
			chk(24'(got_kind), 24'(k));
			if (k < 5) chk(24'(got_row), 24'h2A5);
		end
		core_busy = 1'b1;
		frame(OP_ER_PAGE, ROW_A, 1'b1, 0, 8'h00, 1'b0);
		outcome(1'b0, 1'b1);
		core_busy = 1'b0;
	endtask : s_core
	task automatic s_guard;
		frame(OP_MAP_WR, ROW_P, 1'b1, 1, 8'h01, 1'b0);
		outcome(1'b0, 1'b0);
		wp_n = 1'b0;
		frame(OP_ER_PAGE, ROW_A, 1'b1, 0, 8'h00, 1'b0);
		outcome(1'b0, 1'b1);
		frame(OP_MAP_WR, ROW_P, 1'b1, 1, 8'h00, 1'b0);
		outcome(1'b0, 1'b1);
		frame(OP_ARM, ROW_P, 1'b0, 0, 8'h00, 1'b0);
		outcome(1'b0, 1'b0);
		wp_n = 1'b1;
		frame(OP_ER_PAGE, ROW_P, 1'b1, 0, 8'h00, 1'b0);
		outcome(1'b0, 1'b1);
		frame(OP_DISARM, ROW_P, 1'b0, 0, 8'h00, 1'b0);
		frame(OP_ER_PAGE, ROW_P, 1'b1, 0, 8'h00, 1'b0);
		outcome(1'b1, 1'b0);
	endtask : s_guard
	task automatic s_reset;
		frame(OP_RD_ARRAY, ROW_A, 1'b1, 0, 8'h00, 1'b0);
		u_sfcfe_host.open_frame(1'b0);
		for (int k = 0; k < 5; k++) begin
			u_sfcfe_host.xfer(OP_RD_ARRAY, rx[0]);
		end
		reset_pin_n = 1'b0;
		u_sfcfe_host.tick(8);
		chk(24'(so_oe), 24'h0);
		chk(24'(core_abort), 24'h1);
		reset_pin_n = 1'b1;
		u_sfcfe_host.close_frame;
		frame(OP_ER_PAGE, ROW_A, 1'b1, 0, 8'h00, 1'b0);
		outcome(1'b1, 1'b0);
	endtask : s_reset
	task automatic tally_and_finish;
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		reset_pin_n = 1'b1;
		binary_pages = 1'b0;
		core_busy = 1'b0;
		array_rd_data = 8'h00;
		repeat (16) @(posedge clk);
		#5 rst_n = 1'b1;
		u_sfcfe_host.tick(6);
		s_read(1'b0, {3'h0, 12'hA5C, 9'h13A});
		s_read(1'b1, {4'h0, 12'h3C1, 8'h7E});
		s_buf(1'b0, OP_WR_BUF1, OP_RD_BUF1, 24'h000106);
		s_buf(1'b1, OP_WR_BUF2, OP_RD_BUF2, 24'h0001FE);
		s_core;
		s_guard;
		s_reset;
		tally_and_finish;
	end
endmodule : sfcfe_top_bench
`default_nettype wire
